// ### fp_event_cfg.svh
// Purpose: constants for the float and packed-integer uop event selector
// Assumes: included by bare name from design files
// Notes: codes and mask bit positions as used by the event select and event mask fields
`ifndef FP_EVENT_CFG_SVH
`define FP_EVENT_CFG_SVH

`define EVT_SEL_W 7
`define EVT_MASK_W 16
`define UOP_CLASS_W 3
`define UOP_PORT_W 2
`define LANES_DEFAULT 4

`define EVT_SCALAR_DOUBLE 7'h0E
`define EVT_PACKED_INT64 7'h02
`define EVT_PACKED_INT128 7'h1A
`define EVT_STACK_ARITH 7'h04
`define EVT_FLOAT_MOVE 7'h2E

`define MASK_ALL_BIT 15
`define MASK_MOVE_P0_BIT 3
`define MASK_MOVE_P2_BIT 4

`define EXEC_PORT_0 2'h0
`define EXEC_PORT_2 2'h2

`endif

// ### fp_event_pkg.sv
// Purpose: types shared by the uop event selector files
// Assumes: nothing beyond the cfg header widths
// Notes: class codes are assigned by the dispatch stage
package fp_event_pkg;

  typedef enum logic [2:0] {
    UOP_OTHER         = 3'h0,
    UOP_SCALAR_DOUBLE = 3'h1,
    UOP_PACKED_INT64  = 3'h2,
    UOP_PACKED_INT128 = 3'h3,
    UOP_STACK_ARITH   = 3'h4,
    UOP_STACK_MOVE    = 3'h5,
    UOP_VECTOR_MOVE   = 3'h6
  } uop_class_t;

endpackage : fp_event_pkg

// ### uop_lane_match.sv
// Purpose: decide whether one dispatched uop matches the selected event
// Assumes: class and port codes come from the dispatch stage
// Notes: purely combinational, one instance per dispatch lane
`include "fp_event_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module uop_lane_match
  import fp_event_pkg::*;
(
  input wire logic lane_valid,
  input wire logic [`UOP_CLASS_W-1:0] lane_class,
  input wire logic [`UOP_PORT_W-1:0] lane_port,
  input wire logic [`EVT_SEL_W-1:0] event_select,
  input wire logic [`EVT_MASK_W-1:0] event_mask,
  output logic lane_hit
);

  wire logic mask_all = event_mask[`MASK_ALL_BIT];
  wire logic sel_sd = (event_select == `EVT_SCALAR_DOUBLE);
  wire logic sel_p64 = (event_select == `EVT_PACKED_INT64);
  wire logic sel_p128 = (event_select == `EVT_PACKED_INT128);
  wire logic sel_stack = (event_select == `EVT_STACK_ARITH);
  wire logic sel_move = (event_select == `EVT_FLOAT_MOVE);

  wire logic is_sd = (lane_class == UOP_SCALAR_DOUBLE);
  wire logic is_p64 = (lane_class == UOP_PACKED_INT64);
  wire logic is_p128 = (lane_class == UOP_PACKED_INT128);
  // stack moves form their own class so the arithmetic event never sees them
  wire logic is_stack = (lane_class == UOP_STACK_ARITH);
  wire logic is_move = (lane_class == UOP_STACK_MOVE) || (lane_class == UOP_VECTOR_MOVE);

  // move uops only count on ports 0 and 2, each under its own mask bit; other ports are ignored
  wire logic on_p0 = (lane_port == `EXEC_PORT_0);
  wire logic on_p2 = (lane_port == `EXEC_PORT_2);
  wire logic move_ok = (on_p0 && event_mask[`MASK_MOVE_P0_BIT]) || (on_p2 && event_mask[`MASK_MOVE_P2_BIT]);

  wire logic hit_sd = sel_sd && mask_all && is_sd;
  wire logic hit_p64 = sel_p64 && mask_all && is_p64;
  wire logic hit_p128 = sel_p128 && mask_all && is_p128;
  wire logic hit_stack = sel_stack && mask_all && is_stack;
  wire logic hit_move = sel_move && is_move && move_ok;

  assign lane_hit = lane_valid && (hit_sd || hit_p64 || hit_p128 || hit_stack || hit_move);

endmodule : uop_lane_match

`default_nettype wire

// ### fp_simd_uop_event_selector.sv
// What this block does
// - code 0EH with mask bit 15 counts scalar double-precision uops
// - each scalar double uop counts once, not once per instruction
// - code 02H with mask bit 15 counts 64-bit packed-integer uops
// - each 64-bit packed-integer uop adds one count
// - code 1AH with mask bit 15 counts 128-bit packed-integer uops
// - each 128-bit packed-integer uop counts separately
// - code 04H with mask bit 15 counts stack floating-point arithmetic uops
// - stack event ignores pure load, store and register move uops
// - each stack arithmetic uop increments once
// - code 2EH counts float and vector load, store, move uops per mask
// - move uops are detected at dispatch to port 0 or port 2
//
// Purpose: qualify dispatched uops against the selected event, drive counter increment
// Assumes: dispatch lanes and select fields are synchronous to ref_clk
// Notes: one cycle of latency from dispatch to increment
`include "fp_event_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fp_simd_uop_event_selector
  import fp_event_pkg::*;
#(
  parameter int LANES = `LANES_DEFAULT,
  parameter int CNT_W = $clog2(LANES + 1)
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [`EVT_SEL_W-1:0] event_select,
  input wire logic [`EVT_MASK_W-1:0] event_mask,
  input wire logic [LANES-1:0] uop_valid,
  input wire logic [`UOP_CLASS_W*LANES-1:0] uop_class,
  input wire logic [`UOP_PORT_W*LANES-1:0] uop_port,
  output logic [CNT_W-1:0] count_incr,
  output logic event_hit,
  output logic select_known,
  output logic [LANES-1:0] lane_hit
);

  // population count; the sum is what keeps same-cycle matches from merging
  function automatic logic [CNT_W-1:0] count_lanes(input logic [LANES-1:0] v);
    logic [CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < LANES; i++) begin
      n = n + {{(CNT_W-1){1'b0}}, v[i]};
    end
    return n;
  endfunction : count_lanes

  wire logic [LANES-1:0] hit_vec;
  wire logic [CNT_W-1:0] hit_sum;
  wire logic known_code;

  logic [CNT_W-1:0] count_incr_reg;
  logic [CNT_W-1:0] count_incr_next;
  logic event_hit_reg;
  logic event_hit_next;
  logic select_known_reg;
  logic select_known_next;
  logic [LANES-1:0] lane_hit_reg;
  logic [LANES-1:0] lane_hit_next;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      uop_lane_match u_match (
        .lane_valid(uop_valid[g]),
        .lane_class(uop_class[`UOP_CLASS_W*g +: `UOP_CLASS_W]),
        .lane_port(uop_port[`UOP_PORT_W*g +: `UOP_PORT_W]),
        .event_select(event_select),
        .event_mask(event_mask),
        .lane_hit(hit_vec[g])
      );
    end
  endgenerate

  // one count per matching uop, never per instruction
  assign hit_sum = count_lanes(hit_vec);

  assign known_code = (event_select == `EVT_SCALAR_DOUBLE) ||
                      (event_select == `EVT_PACKED_INT64) ||
                      (event_select == `EVT_PACKED_INT128) ||
                      (event_select == `EVT_STACK_ARITH) ||
                      (event_select == `EVT_FLOAT_MOVE);

  assign count_incr_next = clk_en ? hit_sum : count_incr_reg;
  assign event_hit_next = clk_en ? (|hit_vec) : event_hit_reg;
  assign select_known_next = clk_en ? known_code : select_known_reg;
  assign lane_hit_next = clk_en ? hit_vec : lane_hit_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_incr_reg <= '0;
      event_hit_reg <= 1'b0;
      select_known_reg <= 1'b0;
      lane_hit_reg <= '0;
    end else begin
      count_incr_reg <= count_incr_next;
      event_hit_reg <= event_hit_next;
      select_known_reg <= select_known_next;
      lane_hit_reg <= lane_hit_next;
    end
  end

  assign count_incr = count_incr_reg;
  assign event_hit = event_hit_reg;
  assign select_known = select_known_reg;
  assign lane_hit = lane_hit_reg;

  // helper vectors built independently of the lane matchers
  wire logic [LANES-1:0] chk_sd;
  wire logic [LANES-1:0] chk_p64;
  wire logic [LANES-1:0] chk_p128;
  wire logic [LANES-1:0] chk_stack;
  wire logic [LANES-1:0] chk_move;
  wire logic [LANES-1:0] chk_move_p02;
  wire logic [LANES-1:0] chk_move_p0;
  wire logic [LANES-1:0] chk_move_p2;
  wire logic [LANES-1:0] chk_stack_move;

  generate
    for (g = 0; g < LANES; g++) begin : g_chk
      wire logic [`UOP_CLASS_W-1:0] c = uop_class[`UOP_CLASS_W*g +: `UOP_CLASS_W];
      wire logic [`UOP_PORT_W-1:0] p = uop_port[`UOP_PORT_W*g +: `UOP_PORT_W];
      wire logic mv = (c == UOP_STACK_MOVE) || (c == UOP_VECTOR_MOVE);
      assign chk_sd[g] = uop_valid[g] && (c == UOP_SCALAR_DOUBLE);
      assign chk_p64[g] = uop_valid[g] && (c == UOP_PACKED_INT64);
      assign chk_p128[g] = uop_valid[g] && (c == UOP_PACKED_INT128);
      assign chk_stack[g] = uop_valid[g] && (c == UOP_STACK_ARITH);
      assign chk_move[g] = uop_valid[g] && mv;
      assign chk_move_p0[g] = uop_valid[g] && mv && (p == `EXEC_PORT_0);
      assign chk_move_p2[g] = uop_valid[g] && mv && (p == `EXEC_PORT_2);
      assign chk_move_p02[g] = chk_move_p0[g] || chk_move_p2[g];
      assign chk_stack_move[g] = uop_valid[g] && (c == UOP_STACK_MOVE);
    end
  endgenerate

  wire logic [CNT_W-1:0] n_sd = count_lanes(chk_sd);
  wire logic [CNT_W-1:0] n_p64 = count_lanes(chk_p64);
  wire logic [CNT_W-1:0] n_p128 = count_lanes(chk_p128);
  wire logic [CNT_W-1:0] n_stack = count_lanes(chk_stack);
  wire logic [CNT_W-1:0] n_move02 = count_lanes(chk_move_p02);
  wire logic [CNT_W-1:0] n_move_p0 = count_lanes(chk_move_p0);
  wire logic mask_all = event_mask[`MASK_ALL_BIT];
  wire logic mask_p0 = event_mask[`MASK_MOVE_P0_BIT];
  wire logic mask_p2 = event_mask[`MASK_MOVE_P2_BIT];
  wire logic [CNT_W-1:0] n_move_p2 = count_lanes(chk_move_p2);
  wire logic sel_in_set = event_select inside {`EVT_SCALAR_DOUBLE, `EVT_PACKED_INT64, `EVT_PACKED_INT128, `EVT_STACK_ARITH, `EVT_FLOAT_MOVE};

  sequence s_sel_sd;
    clk_en && (event_select == `EVT_SCALAR_DOUBLE) && mask_all;
  endsequence

  sequence s_sel_p64;
    clk_en && (event_select == `EVT_PACKED_INT64) && mask_all;
  endsequence

  sequence s_sel_p128;
    clk_en && (event_select == `EVT_PACKED_INT128) && mask_all;
  endsequence

  sequence s_sel_stack;
    clk_en && (event_select == `EVT_STACK_ARITH) && mask_all;
  endsequence

  sequence s_sel_move_both;
    clk_en && (event_select == `EVT_FLOAT_MOVE) && mask_p0 && mask_p2;
  endsequence

  a_scalar_double_count: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_sd |=> (count_incr == $past(n_sd)))
    else $error("scalar double increment does not match dispatched uops");

  a_scalar_per_uop: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_sd ##0 (chk_sd == {LANES{1'b1}}) |=> (count_incr == CNT_W'(LANES)))
    else $error("several scalar double uops not all counted");

  a_packed64_count: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_p64 |=> (count_incr == $past(n_p64)))
    else $error("packed 64 increment does not match dispatched uops");

  a_packed64_per_uop: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_p64 ##0 (n_p64 > 1) |=> (count_incr > 1) && (lane_hit == $past(chk_p64)))
    else $error("packed 64 uops merged into one count");

  a_packed128_count: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_p128 |=> (count_incr == $past(n_p128)))
    else $error("packed 128 increment does not match dispatched uops");

  a_packed128_lanes: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_p128 |=> (lane_hit == $past(chk_p128)))
    else $error("packed 128 lane hits wrong");

  a_stack_arith_count: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_stack |=> (count_incr == $past(n_stack)))
    else $error("stack arithmetic increment does not match dispatched uops");

  a_stack_no_moves: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en && (event_select == `EVT_STACK_ARITH) && (chk_stack == '0) |=> (count_incr == '0) && !event_hit)
    else $error("stack arithmetic event counted a move uop");

  a_stack_per_uop: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_stack |=> (lane_hit == $past(chk_stack)))
    else $error("stack arithmetic lane hits wrong");

  a_move_count: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_move_both |=> (count_incr == $past(n_move02)))
    else $error("move increment does not match uops on ports 0 and 2");

  a_move_port_only: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en && (event_select == `EVT_FLOAT_MOVE) && mask_p0 && !mask_p2 |=> (count_incr == $past(n_move_p0)))
    else $error("move uop counted on wrong port");

  a_sum_matches_lanes: assert property (
    @(posedge ref_clk) disable iff (srst)
    (count_incr == count_lanes(lane_hit)) && (event_hit == (count_incr != '0)))
    else $error("increment differs from number of lane hits");

  a_scalar_double_lanes: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_sd |=> (lane_hit == $past(chk_sd)))
    else $error("scalar double lane hits wrong");

  a_packed64_lanes: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_p64 |=> (lane_hit == $past(chk_p64)))
    else $error("packed 64 lane hits wrong");

  a_packed128_per_uop: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_p128 ##0 (chk_p128 == {LANES{1'b1}}) |=> (count_incr == CNT_W'(LANES)))
    else $error("several packed 128 uops not all counted");

  a_mask_all_needed: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en && (event_select != `EVT_FLOAT_MOVE) && !mask_all |=> (count_incr == '0))
    else $error("uop counted without mask bit 15");

  // a stack load or move on any lane must never show up as an arithmetic hit
  a_stack_skip_moves: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_stack |=> ((lane_hit & $past(chk_stack_move)) == '0))
    else $error("stack arithmetic event hit a stack move lane");

  a_move_lanes: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_sel_move_both |=> (lane_hit == $past(chk_move_p02)))
    else $error("move lane hits wrong");

  a_move_no_port_mask: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en && (event_select == `EVT_FLOAT_MOVE) && !mask_p0 && !mask_p2 |=> (count_incr == '0))
    else $error("move counted with both port mask bits clear");

  a_move_port2_only: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en && (event_select == `EVT_FLOAT_MOVE) && !mask_p0 && mask_p2 |=> (count_incr == $past(n_move_p2)))
    else $error("move uop counted on wrong port");

  a_unknown_no_count: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en && !sel_in_set |=> (count_incr == '0) && (lane_hit == '0))
    else $error("unknown event code counted uops");

  a_select_known_code: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en |=> (select_known == $past(sel_in_set)))
    else $error("select known flag wrong");

  a_hits_from_valid: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en |=> ((lane_hit & ~$past(uop_valid)) == '0))
    else $error("lane hit without a valid uop");

  a_enable_freeze_hit: assert property (
    @(posedge ref_clk) disable iff (srst)
    !clk_en |=> $stable(event_hit))
    else $error("event hit moved while clock enable low");

  a_enable_freeze: assert property (
    @(posedge ref_clk) disable iff (srst)
    !clk_en |=> $stable(count_incr) && $stable(lane_hit) && $stable(select_known))
    else $error("outputs moved while clock enable low");

  a_reset_clear: assert property (
    @(posedge ref_clk)
    srst |=> (count_incr == '0) && !event_hit && !select_known && (lane_hit == '0))
    else $error("outputs not cleared by reset");

endmodule : fp_simd_uop_event_selector

`default_nettype wire

// ### uop_dispatch_model.sv
// Purpose: stand-in for the dispatch stage that feeds uops to the event selector
// Assumes: called from the bench; every change lands just after a ref_clk edge
// Notes: idle lanes show the inverse of their last class and port, not a stale copy
`include "fp_event_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module uop_dispatch_model
  import fp_event_pkg::*;
(
  input wire logic ref_clk,
  output logic [`LANES_DEFAULT-1:0] uop_valid,
  output logic [`UOP_CLASS_W*`LANES_DEFAULT-1:0] uop_class,
  output logic [`UOP_PORT_W*`LANES_DEFAULT-1:0] uop_port
);
  initial begin
    uop_valid = 4'h0;
    uop_class = 12'h000;
    uop_port = 8'h00;
  end

  // one dispatch group per call; idle lanes toggle so stale codes cannot match by luck
  task automatic send(input logic [3:0] v, input logic [11:0] c, input logic [7:0] p);
    logic [11:0] cq;
    logic [7:0] pq;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      cq[3*i+:3] = v[i] ? c[3*i+:3] : ~uop_class[3*i+:3];
      pq[2*i+:2] = v[i] ? p[2*i+:2] : ~uop_port[2*i+:2];
    end
    uop_valid <= v;
    uop_class <= cq;
    uop_port <= pq;
  endtask : send
endmodule : uop_dispatch_model
`default_nettype wire

// ### fp_simd_uop_event_selector_test.sv
// Purpose: self-checking bench for the float and packed-integer uop event selector
// Assumes: LANES=4, one cycle from dispatch to increment
// Notes: select and mask are driven with each dispatch group
`include "fp_event_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fp_simd_uop_event_selector_test
  import fp_event_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic [6:0] event_select = 7'h00;
  logic [15:0] event_mask = 16'h0000;
  logic [3:0] uop_valid;
  logic [11:0] uop_class;
  logic [7:0] uop_port;
  logic [2:0] count_incr;
  logic event_hit;
  logic select_known;
  logic [3:0] lane_hit;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [6:0] codes [4] = '{`EVT_SCALAR_DOUBLE, `EVT_PACKED_INT64, `EVT_PACKED_INT128, `EVT_STACK_ARITH};
  uop_class_t kinds [4] = '{UOP_SCALAR_DOUBLE, UOP_PACKED_INT64, UOP_PACKED_INT128, UOP_STACK_ARITH};

  always #20 ref_clk = ~ref_clk;

  uop_dispatch_model disp_u (.ref_clk(ref_clk), .uop_valid(uop_valid), .uop_class(uop_class), .uop_port(uop_port));

  fp_simd_uop_event_selector #(.LANES(4)) dut_u (
    .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .event_select(event_select), .event_mask(event_mask),
    .uop_valid(uop_valid), .uop_class(uop_class), .uop_port(uop_port), .count_incr(count_incr),
    .event_hit(event_hit), .select_known(select_known), .lane_hit(lane_hit));

  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // drive one group, then judge the increment one edge later
  task automatic run(input logic [6:0] sel, input logic [15:0] m, input logic [3:0] v, input logic [11:0] c,
                     input logic [7:0] p, input logic [2:0] n, input logic [3:0] hits, input logic known);
    disp_u.send(v, c, p);
    event_select <= sel;
    event_mask <= m;
    @(posedge ref_clk);
    #1;
    chk("count_incr", {13'h0, n}, {13'h0, count_incr});
    chk("lane_hit", {12'h0, hits}, {12'h0, lane_hit});
    chk("event_hit", {15'h0, (n != 3'h0)}, {15'h0, event_hit});
    chk("select_known", {15'h0, known}, {15'h0, select_known});
  endtask : run

  // each code picks only its own class out of a mixed group, all four lanes sum, no bit15 gives nothing
  task automatic test_codes();
    for (int i = 0; i < 4; i++) begin
      run(codes[i], 16'h8000, 4'hF, {kinds[3], kinds[2], kinds[1], kinds[0]}, 8'h00, 3'h1, 4'h1 << i, 1'b1);
      run(codes[i], 16'h8000, 4'hF, {4{kinds[i]}}, 8'h00, 3'h4, 4'hF, 1'b1);
      run(codes[i], 16'h7FFF, 4'hF, {4{kinds[i]}}, 8'h00, 3'h0, 4'h0, 1'b1);
    end
  endtask : test_codes

  // load, store and move uops never count as stack arithmetic
  task automatic test_stack_moves();
    run(`EVT_STACK_ARITH, 16'h8000, 4'hF, {UOP_OTHER, UOP_STACK_ARITH, UOP_STACK_MOVE, UOP_STACK_ARITH},
        8'h00, 3'h2, 4'h5, 1'b1);
  endtask : test_stack_moves

  // move uops count on port 0 and port 2 only, each under its own mask bit
  task automatic test_moves();
    logic [11:0] c;
    c = {UOP_VECTOR_MOVE, UOP_VECTOR_MOVE, UOP_STACK_MOVE, UOP_VECTOR_MOVE};
    run(`EVT_FLOAT_MOVE, 16'h0018, 4'hF, c, 8'hD8, 3'h2, 4'h3, 1'b1);
    run(`EVT_FLOAT_MOVE, 16'h0008, 4'hF, c, 8'hD8, 3'h1, 4'h1, 1'b1);
    run(`EVT_FLOAT_MOVE, 16'h0010, 4'h7, c, 8'hD8, 3'h1, 4'h2, 1'b1);
    run(`EVT_FLOAT_MOVE, 16'h8000, 4'hF, c, 8'hD8, 3'h0, 4'h0, 1'b1);
    run(`EVT_FLOAT_MOVE, 16'h0018, 4'hF, {4{UOP_SCALAR_DOUBLE}}, 8'h00, 3'h0, 4'h0, 1'b1);
  endtask : test_moves

  // a neighbouring code outside this block counts nothing
  task automatic test_unknown();
    run(7'h0C, 16'hFFFF, 4'hF, {4{UOP_SCALAR_DOUBLE}}, 8'h00, 3'h0, 4'h0, 1'b0);
  endtask : test_unknown

  // a disabled clock freezes the increment, reset clears it even while disabled
  task automatic test_hold_reset();
    run(`EVT_SCALAR_DOUBLE, 16'h8000, 4'hF, {4{UOP_SCALAR_DOUBLE}}, 8'h00, 3'h4, 4'hF, 1'b1);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    disp_u.send(4'h0, 12'h000, 8'h00);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("count_incr held", 16'h0004, {13'h0, count_incr});
    chk("lane_hit held", 16'h000F, {12'h0, lane_hit});
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("count_incr reset", 16'h0000, {13'h0, count_incr});
    chk("select_known reset", 16'h0000, {15'h0, select_known});
    @(posedge ref_clk);
    srst <= 1'b0;
    clk_en <= 1'b1;
  endtask : test_hold_reset

  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    test_codes();
    test_stack_moves();
    test_moves();
    test_unknown();
    test_hold_reset();
    test_codes();
    stop_test();
  end

  // the whole run needs about 80 cycles, well under this 2000-cycle limit
  initial begin
    #(40 * 2000);
    n_mismatch++;
    stop_test();
  end
endmodule : fp_simd_uop_event_selector_test
`default_nettype wire
